// ### rtl/cache_id_pkg.sv
// constants, field layout and carrier types of the cache identification bank
package cache_id_pkg;

   // ****************************************
   // coprocessor access codes
   // ****************************************
   localparam logic [3:0] CRN_ID            = 4'h0;
   localparam logic [3:0] CRM_ID            = 4'h0;
   localparam logic [2:0] OP1_LEVEL_ONE_ID  = 3'h1;
   localparam logic [2:0] OP1_SELECT        = 3'h2;
   localparam logic [2:0] OP2_SIZE_ID       = 3'h0;
   localparam logic [2:0] OP2_LEVEL_ID      = 3'h1;
   localparam logic [2:0] OP2_AUX_ID        = 3'h7;
   localparam logic [2:0] OP2_SELECT        = 3'h0;

   // ****************************************
   // selection register layout
   // ****************************************
   localparam int         SEL_LEVEL_LSB     = 1;
   localparam int         SEL_IND_BIT       = 0;
   localparam logic [2:0] SEL_LEVEL1        = 3'h0;
   localparam logic [2:0] SEL_LEVEL2        = 3'h1;
   localparam logic [3:0] SEL_RESET         = 4'h0;

   // ****************************************
   // size word layout and per-cache attributes
   // ****************************************
   localparam int         SIZE_SETS_LSB     = 13;
   localparam int         SIZE_WAYS_LSB     = 3;
   localparam logic [3:0] L1D_POLICY        = 4'h7;
   localparam logic [3:0] L1I_POLICY        = 4'h2;
   localparam logic [3:0] L2_POLICY         = 4'h7;
   localparam int         L1D_WAYS          = 4;
   localparam int         L1I_WAYS          = 2;
   localparam int         L2_WAYS           = 8;
   localparam logic [2:0] L1D_LINE_CODE     = 3'h2;
   localparam logic [2:0] L1I_LINE_CODE     = 3'h1;
   localparam logic [2:0] L2_LINE_CODE      = 3'h2;
   localparam int         L1D_LINE_BYTES    = 64;
   localparam int         L1I_LINE_BYTES    = 32;
   localparam int         L2_LINE_BYTES     = 64;
   localparam logic [31:0] SIZE_RESERVED    = 32'h0000_0000;

   // ****************************************
   // level identification fields
   // ****************************************
   localparam logic [2:0] UNIF_UNI_LEVEL    = 3'h1;
   localparam logic [2:0] COH_LEVEL_NO_L2   = 3'h1;
   localparam logic [2:0] COH_LEVEL_L2      = 3'h2;
   localparam logic [2:0] UNIF_IS_LEVEL     = 3'h1;
   localparam logic [2:0] L2_TYPE_NONE      = 3'h0;
   localparam logic [2:0] L2_TYPE_UNIFIED   = 3'h4;
   localparam logic [2:0] L1_TYPE_SPLIT     = 3'h3;
   localparam logic [31:0] AUX_ID_VALUE     = 32'h0000_0000;

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic        valid;
      logic        write;
      logic        secure;
      logic        privileged;
      logic [2:0]  opcode1;
      logic [3:0]  crn;
      logic [3:0]  crm;
      logic [2:0]  opcode2;
      logic [31:0] wdata;
   } cp_req_t;

   typedef struct packed {
      logic        valid;
      logic        undef;
      logic [31:0] rdata;
   } cp_resp_t;

endpackage

// ### rtl/cache_id_regs.sv
// cache identification and selection registers on the coprocessor port
// Operation
// - size word follows cache picked by selection level and type fields
// - selection level at bits 3..1: 0 level one, 1 level two, rest reserved
// - selection bit 0: zero data or unified, one instruction cache
// - uniprocessor unification level field 29..27 reads 1
// - coherency level 26..24 reads 1 without level two, 2 with it
// - inner shareable unification level 23..21 reads 1
// - level-two type 5..3 reads 0 when absent, 4 unified when present
// - level-one type 2..0 reads 3, split instruction and data
// - level register read-only, common, privileged; 31..30 and 20..6 zero
// - auxiliary identification reads zero, writes ignored
// - selection read/write, banked per security state, privileged only
// - size word: policy bits 31..28, sets 27..13, ways 12..3, line 2..0
`timescale 1ns/1ps
module cache_id_regs
   import cache_id_pkg::*;
#(
   parameter int L1I_SIZE_KB = 32,
   parameter int L1D_SIZE_KB = 32,
   parameter bit L2_PRESENT  = 1'b1,
   parameter int L2_SIZE_KB  = 512
) (
   input  wire logic     clk,
   input  wire logic     rst_n,
   input  wire cp_req_t  cpReq,
   output cp_resp_t      cpResp
);

   // ****************************************
   // derived identification words
   // ****************************************
   function automatic logic [31:0] sizeWord(input logic [3:0] policy, input int kb,
                                            input int ways, input int lineBytes,
                                            input logic [2:0] lineCode);
      int sets;
      logic [31:0] w;
      sets = (kb * 1024) / (ways * lineBytes) - 1;
      w = '0;
      w[31:28] = policy;
      w[27:SIZE_SETS_LSB] = 15'(sets);
      w[12:SIZE_WAYS_LSB] = 10'(ways - 1);
      w[2:0] = lineCode;
      return w;
   endfunction

   localparam logic [31:0] L1D_WORD =
      sizeWord(L1D_POLICY, L1D_SIZE_KB, L1D_WAYS, L1D_LINE_BYTES, L1D_LINE_CODE);
   localparam logic [31:0] L1I_WORD =
      sizeWord(L1I_POLICY, L1I_SIZE_KB, L1I_WAYS, L1I_LINE_BYTES, L1I_LINE_CODE);
   localparam logic [31:0] L2_WORD =
      sizeWord(L2_POLICY, L2_SIZE_KB, L2_WAYS, L2_LINE_BYTES, L2_LINE_CODE);

   localparam logic [31:0] LEVEL_WORD = {2'b00,
      UNIF_UNI_LEVEL,
      (L2_PRESENT ? COH_LEVEL_L2 : COH_LEVEL_NO_L2),
      UNIF_IS_LEVEL,
      15'h0000,
      (L2_PRESENT ? L2_TYPE_UNIFIED : L2_TYPE_NONE),
      L1_TYPE_SPLIT};

   function automatic logic [31:0] pickSize(input logic [3:0] sel);
      logic [2:0] lvl;
      lvl = sel[3:SEL_LEVEL_LSB];
      if (lvl == SEL_LEVEL1 && !sel[SEL_IND_BIT]) begin
         return L1D_WORD;
      end else if (lvl == SEL_LEVEL1) begin
         return L1I_WORD;
      end else if (lvl == SEL_LEVEL2 && !sel[SEL_IND_BIT] && L2_PRESENT) begin
         return L2_WORD;
      end
      return SIZE_RESERVED;
   endfunction

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [3:0] selSecure;
      logic [3:0] selNonSecure;
      cp_resp_t   resp;
   } state_t;

   state_t state_reg;
   state_t state_next;

   // ****************************************
   // access decode
   // ****************************************
   always_comb begin
      logic       hit;
      logic [3:0] curSel;
      hit        = cpReq.valid && cpReq.crn == CRN_ID && cpReq.crm == CRM_ID;
      curSel     = cpReq.secure ? state_reg.selSecure : state_reg.selNonSecure;
      state_next = state_reg;
      state_next.resp.valid = cpReq.valid;
      state_next.resp.undef = 1'b0;
      state_next.resp.rdata = '0;
      if (cpReq.valid) begin
         if (!cpReq.privileged) begin
            state_next.resp.undef = 1'b1;
         end else if (hit && cpReq.opcode1 == OP1_SELECT && cpReq.opcode2 == OP2_SELECT) begin
            if (cpReq.write) begin
               if (cpReq.secure) begin
                  state_next.selSecure = cpReq.wdata[3:0];
               end else begin
                  state_next.selNonSecure = cpReq.wdata[3:0];
               end
            end else begin
               state_next.resp.rdata = {28'h000_0000, curSel};
            end
         end else if (hit && cpReq.opcode1 == OP1_LEVEL_ONE_ID
                      && cpReq.opcode2 == OP2_AUX_ID) begin
            if (!cpReq.write) begin
               state_next.resp.rdata = AUX_ID_VALUE;
            end
         end else if (hit && cpReq.opcode1 == OP1_LEVEL_ONE_ID && !cpReq.write
                      && cpReq.opcode2 == OP2_SIZE_ID) begin
            state_next.resp.rdata = pickSize(curSel);
         end else if (hit && cpReq.opcode1 == OP1_LEVEL_ONE_ID && !cpReq.write
                      && cpReq.opcode2 == OP2_LEVEL_ID) begin
            state_next.resp.rdata = LEVEL_WORD;
         end else begin
            state_next.resp.undef = 1'b1;
         end
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_reg <= '{selSecure: SEL_RESET, selNonSecure: SEL_RESET, resp: '0};
      end else begin
         state_reg <= state_next;
      end
   end

   assign cpResp = state_reg.resp;

endmodule

// ### verif/cache_id_regs_assertions.sv
// checker of the cache identification bank
`timescale 1ns/1ps
module cache_id_regs_checker
   import cache_id_pkg::*;
#(
   parameter int L1I_SIZE_KB = 32,
   parameter int L1D_SIZE_KB = 32,
   parameter bit L2_PRESENT  = 1'b1,
   parameter int L2_SIZE_KB  = 512
) (
   input wire logic     clk,
   input wire logic     rst_n,
   input wire cp_req_t  cpReq,
   input wire cp_resp_t cpResp
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   sequence acc(logic w, logic [2:0] o1, logic [2:0] o2);
      cpReq.valid && cpReq.write == w && cpReq.privileged && cpReq.opcode1 == o1
         && cpReq.crn == 4'h0 && cpReq.crm == 4'h0 && cpReq.opcode2 == o2;
   endsequence
   chk_level_uniproc: assert property (acc(0, 1, 1) |=> cpResp.rdata[29:27] == 3'h1)
      else $error("uniprocessor unification level wrong");
   chk_level_coherency: assert property (acc(0, 1, 1) |=>
      cpResp.rdata[26:24] == (L2_PRESENT ? 3'h2 : 3'h1)) else $error("coherency level wrong");
   chk_level_shareable: assert property (acc(0, 1, 1) |=> cpResp.rdata[23:21] == 3'h1)
      else $error("shareable unification level wrong");
   chk_level_l2type: assert property (acc(0, 1, 1) |=>
      cpResp.rdata[5:3] == (L2_PRESENT ? 3'h4 : 3'h0)) else $error("level two type wrong");
   chk_level_l1type: assert property (acc(0, 1, 1) |=> cpResp.rdata[2:0] == 3'h3)
      else $error("level one type wrong");
   chk_level_reserved: assert property (acc(0, 1, 1) |=> !cpResp.undef &&
      cpResp.rdata[31:30] == 2'h0 && cpResp.rdata[20:6] == 15'h0) else $error("level word bad");
   chk_aux_zero: assert property (acc(cpReq.write, 1, 7) |=>
      cpResp.valid && !cpResp.undef && cpResp.rdata == 32'h0000_0000) else $error("aux not zero");
   chk_unpriv_refused: assert property (cpReq.valid && !cpReq.privileged |=>
      cpResp.undef && cpResp.rdata == 32'h0000_0000) else $error("unprivileged not refused");
   chk_sel_readback: assert property ((acc(1, 2, 0) ##1 acc(0, 2, 0) ##0
      cpReq.secure == $past(cpReq.secure)) |=> cpResp.rdata == {28'h0, $past(cpReq.wdata[3:0], 2)})
      else $error("selection readback wrong");
endmodule
bind cache_id_regs cache_id_regs_checker #(.L1I_SIZE_KB(L1I_SIZE_KB), .L1D_SIZE_KB(L1D_SIZE_KB),
   .L2_PRESENT(L2_PRESENT), .L2_SIZE_KB(L2_SIZE_KB)) i_chk (.clk(clk), .rst_n(rst_n),
   .cpReq(cpReq), .cpResp(cpResp));

// ### verif/cache_id_regs_tb.sv
// self-checking bench of the cache identification bank
`timescale 1ns/1ps
module cache_id_regs_tb
   import cache_id_pkg::*;
;
   localparam int L1I = 64;
   localparam int L1D = 8;
   localparam bit L2P = 1'b1;
   localparam int L2  = 1024;
   localparam int L1I_ALT = 8;
   localparam int L1D_ALT = 64;
   localparam bit L2P_ALT = 1'b0;
   localparam int L2_ALT  = 128;
   logic        clk;
   logic        rst_n;
   cp_req_t     req;
   cp_resp_t    resp;
   cp_resp_t    resp2;
   logic [33:0] r;
   logic [33:0] r2;
   logic [3:0]  sel;
   logic        s;
   int          n_errors;
   int          total_checks;
   cache_id_regs #(.L1I_SIZE_KB(L1I), .L1D_SIZE_KB(L1D), .L2_PRESENT(L2P), .L2_SIZE_KB(L2))
      i_dut (.clk(clk), .rst_n(rst_n), .cpReq(req), .cpResp(resp));
   cache_id_regs #(.L1I_SIZE_KB(L1I_ALT), .L1D_SIZE_KB(L1D_ALT), .L2_PRESENT(L2P_ALT),
      .L2_SIZE_KB(L2_ALT))
      i_dut_alt (.clk(clk), .rst_n(rst_n), .cpReq(req), .cpResp(resp2));
   always #2.5 clk = ~clk;
   function automatic logic [31:0] l1dWord(int kb);
      case (kb)
         8: return 32'h7003_E01A;
         16: return 32'h7007_E01A;
         32: return 32'h700F_E01A;
         64: return 32'h701F_E01A;
         default: return 32'h0000_0000;
      endcase
   endfunction
   function automatic logic [31:0] l1iWord(int kb);
      case (kb)
         8: return 32'h200F_E009;
         16: return 32'h201F_E009;
         32: return 32'h203F_E009;
         64: return 32'h207F_E009;
         default: return 32'h0000_0000;
      endcase
   endfunction
   function automatic logic [31:0] l2Word(int kb);
      case (kb)
         128: return 32'h701F_E03A;
         256: return 32'h703F_E03A;
         512: return 32'h707F_E03A;
         1024: return 32'h70FF_E03A;
         default: return 32'h0000_0000;
      endcase
   endfunction
   function automatic logic [33:0] szExp(logic [3:0] v, int l1i, int l1d, bit l2p, int l2);
      logic [31:0] w;
      w = 32'h0000_0000;
      case (v)
         4'h0: w = l1dWord(l1d);
         4'h1: w = l1iWord(l1i);
         4'h2: w = l2p ? l2Word(l2) : 32'h0000_0000;
         default: w = 32'h0000_0000;
      endcase
      return {2'b10, w};
   endfunction
   function automatic logic [33:0] lvlExp(bit l2p);
      return {2'b10, 5'h01, l2p ? 3'h2 : 3'h1, 3'h1, 15'h0000, l2p ? 3'h4 : 3'h0, 3'h3};
   endfunction
   task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic acc(input logic w, input logic sc, input logic p, input logic [2:0] o1,
                      input logic [2:0] o2, input logic [31:0] d);
      req = '{valid: 1'b1, write: w, secure: sc, privileged: p, opcode1: o1, crn: 4'h0,
              crm: 4'h0, opcode2: o2, wdata: d};
      @(negedge clk);
      r = resp;
      r2 = resp2;
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      req = '0;
      n_errors = 0;
      total_checks = 0;
      void'($urandom(32'h545c));
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      chk(resp, 34'h0_0000_0000);
      acc(1'b0, 1'b1, 1'b1, 3'h2, 3'h0, 32'h0000_0000);
      chk(r, 34'h2_0000_0000);
      for (int i = 0; i < 48; i++) begin
         s = (i < 32) ? i[4] : 1'($urandom);
         sel = (i < 32) ? i[3:0] : 4'($urandom);
         acc(1'b1, !s, 1'b1, 3'h2, 3'h0, {28'h000_0000, ~sel});
         acc(1'b1, s, 1'b1, 3'h2, 3'h0, {28'h000_0000, sel});
         chk(r, 34'h2_0000_0000);
         acc(1'b0, s, 1'b1, 3'h2, 3'h0, $urandom);
         chk(r, {2'b10, 28'h000_0000, sel});
         chk(r2, {2'b10, 28'h000_0000, sel});
         acc(1'b0, s, 1'b1, 3'h1, 3'h0, $urandom);
         chk(r, szExp(sel, L1I, L1D, L2P, L2));
         chk(r2, szExp(sel, L1I_ALT, L1D_ALT, L2P_ALT, L2_ALT));
      end
      acc(1'b1, s, 1'b0, 3'h2, 3'h0, {28'h000_0000, ~sel});
      chk(r, 34'h3_0000_0000);
      acc(1'b0, s, 1'b1, 3'h2, 3'h0, 32'h0000_0000);
      chk(r, {2'b10, 28'h000_0000, sel});
      req = '0;
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      chk(resp, 34'h0_0000_0000);
      acc(1'b0, !s, 1'b1, 3'h2, 3'h0, 32'h0000_0000);
      chk(r, 34'h2_0000_0000);
      acc(1'b0, 1'b0, 1'b1, 3'h1, 3'h1, 32'h0000_0000);
      chk(r, lvlExp(L2P));
      chk(r2, lvlExp(L2P_ALT));
      acc(1'b1, 1'b1, 1'b1, 3'h1, 3'h1, $urandom);
      chk(r, 34'h3_0000_0000);
      acc(1'b1, 1'b1, 1'b1, 3'h1, 3'h7, 32'hFFFF_FFFF);
      chk(r, 34'h2_0000_0000);
      acc(1'b0, 1'b1, 1'b1, 3'h1, 3'h7, 32'h0000_0000);
      chk(r, 34'h2_0000_0000);
      acc(1'b0, 1'b0, 1'b0, 3'h2, 3'h0, 32'h0000_0000);
      chk(r, 34'h3_0000_0000);
      req = '0;
      @(negedge clk);
      wrap_up();
   end
endmodule
